// >>> hw/xip_stream_pkg.sv
// constants for the streaming, status and profiling block
// assumes a 32-bit classic wishbone register bus and a 100 MHz mclk

package xip_stream_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_FLUSH_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_HIT_COUNT = 8'h0C;
    localparam logic [7:0] OFS_ACCESS_COUNT = 8'h10;
    localparam logic [7:0] OFS_STREAM_ADDR = 8'h14;
    localparam logic [7:0] OFS_STREAM_COUNT = 8'h18;
    localparam logic [7:0] OFS_STREAM_DATA = 8'h1C;

    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int STAT_FLUSH_DONE_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_FULL_BIT = 2;
    localparam int FLUSH_GO_BIT = 0;
    localparam int COUNT_W = 22;
    localparam int ADDR_LSB = 2;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // ------------------------------------------------------------------
    // values after reset, and the ceiling at which the counters saturate
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_COUNTER = 32'h0000_0000;
    localparam logic [29:0] RST_STREAM_ADDR = 30'h0000_0000;
    localparam logic [21:0] RST_STREAM_COUNT = 22'h00_0000;
    localparam logic [31:0] RST_BUF_DATA = 32'h0000_0000;
    localparam logic [31:0] COUNTER_MAX = 32'hFFFF_FFFF;

    // ------------------------------------------------------------------
    // timing: length of a tag flush, plain default
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLUSH_TIME_NS = 2560;
    localparam logic [11:0] FLUSH_CYCLES = 12'(FLUSH_TIME_NS / CLK_PERIOD_NS);

endpackage : xip_stream_pkg

// >>> hw/xip_stream_status_counters.sv
// streaming buffer engine, status register and profiling counters
// assumes a classic wishbone master, a flash port that answers one read
// at a time, and hit/access pulses from the cache on the same mclk
//
// Added by the designer: the Wishbone slave port.

`timescale 1ns/1ps
`default_nettype none

module xip_stream_status_counters (
    input wire logic mclk,
    input wire logic rst_b,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // auxiliary read port to the buffer
    input wire logic aux_rd,
    output logic [31:0] aux_rdata,
    // dma request
    output logic stream_dreq,
    // cache events and flush handshake
    input wire logic cache_access,
    input wire logic cache_hit,
    output logic flush_active,
    // flash read port
    input wire logic flash_busy,
    output logic flash_req,
    output logic [31:0] flash_addr,
    input wire logic flash_ack,
    input wire logic [31:0] flash_rdata
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] slot0;
        logic [31:0] slot1;
        logic [1:0] level;
        logic [31:0] hit_cnt;
        logic [31:0] acc_cnt;
        logic [29:0] saddr;
        logic [21:0] scount;
        logic pending;
        logic discard;
        logic freq;
        logic [11:0] flush_cnt;
        logic flush_busy;
        logic ack;
        logic [31:0] dat;
        logic dreq;
    } state_t;

    state_t st_q;
    state_t st_d;

    // saturating increment shared by both counters
    function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic ev);
        sat_inc = (ev && v != xip_stream_pkg::COUNTER_MAX) ? v + 32'h0000_0001 : v;
    endfunction : sat_inc

    // request on the bus that has not yet been answered
    logic bus_req;
    logic wr_go;
    logic rd_go;
    logic aux_pop;
    logic wb_pop;
    logic [1:0] npop;
    logic push;
    logic abort;
    logic issue;
    logic [31:0] rd_word;

    assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr_go = bus_req && wb_we_i;
    assign rd_go = bus_req && !wb_we_i;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.freq = 1'b0;
        st_d.ack = bus_req;

        // pops: aux first, then a wishbone read of the data register
        aux_pop = aux_rd && st_q.level != 2'h0;
        wb_pop = rd_go && wb_adr_i == xip_stream_pkg::OFS_STREAM_DATA
            && st_q.level > {1'b0, aux_pop};
        npop = {1'b0, aux_pop} + {1'b0, wb_pop};
        rd_word = aux_pop ? st_q.slot1 : st_q.slot0;

        // a zero written to the count stops the stream
        abort = wr_go && wb_adr_i == xip_stream_pkg::OFS_STREAM_COUNT
            && wb_dat_i[xip_stream_pkg::COUNT_W-1:0] == 22'h00_0000;
        // a returning read is kept unless it was cancelled
        push = flash_ack && st_q.pending && !st_q.discard && !abort;

        // buffer shift: pops leave from slot0, push lands behind survivors
        unique case (npop)
            2'h1: begin
                st_d.slot0 = st_q.slot1;
            end
            2'h2: begin
                st_d.slot0 = xip_stream_pkg::RST_BUF_DATA;
            end
            default: begin
            end
        endcase
        if (push) begin
            if (st_q.level - npop == 2'h0) begin
                st_d.slot0 = flash_rdata;
            end else begin
                st_d.slot1 = flash_rdata;
            end
        end
        st_d.level = st_q.level - npop + {1'b0, push};

        // completed read: advance address, count one word
        if (push) begin
            st_d.saddr = st_q.saddr + 30'h0000_0001;
            st_d.scount = st_q.scount - 22'h00_0001;
        end
        if (flash_ack) begin
            st_d.pending = 1'b0;
            st_d.discard = 1'b0;
        end

        // issue only when idle flash, no read in flight, and a free slot
        issue = st_q.scount != 22'h00_0000 && !st_q.pending && !st_q.discard
            && !st_q.freq && !flash_busy
            && st_q.level < xip_stream_pkg::BUF_DEPTH && !abort;
        if (issue) begin
            st_d.freq = 1'b1;
            st_d.pending = 1'b1;
        end

        // counters; a clear still keeps an event of the same cycle
        st_d.hit_cnt = sat_inc(st_q.hit_cnt, cache_hit);
        st_d.acc_cnt = sat_inc(st_q.acc_cnt, cache_access);

        // flush timer
        if (st_q.flush_busy) begin
            if (st_q.flush_cnt == xip_stream_pkg::FLUSH_CYCLES - 12'h001) begin
                st_d.flush_busy = 1'b0;
                st_d.flush_cnt = 12'h000;
            end else begin
                st_d.flush_cnt = st_q.flush_cnt + 12'h001;
            end
        end

        // register writes
        if (wr_go) begin
            unique case (wb_adr_i)
                xip_stream_pkg::OFS_FLUSH_CTRL: begin
                    if (wb_sel_i[0] && wb_dat_i[xip_stream_pkg::FLUSH_GO_BIT]) begin
                        st_d.flush_busy = 1'b1;
                        st_d.flush_cnt = 12'h000;
                    end
                end
                xip_stream_pkg::OFS_HIT_COUNT: begin
                    st_d.hit_cnt = {31'h0000_0000, cache_hit};
                end
                xip_stream_pkg::OFS_ACCESS_COUNT: begin
                    st_d.acc_cnt = {31'h0000_0000, cache_access};
                end
                xip_stream_pkg::OFS_STREAM_ADDR: begin
                    st_d.saddr = wb_dat_i[31:xip_stream_pkg::ADDR_LSB];
                end
                xip_stream_pkg::OFS_STREAM_COUNT: begin
                    // nonzero starts, zero halts and cancels the read
                    st_d.scount = wb_dat_i[xip_stream_pkg::COUNT_W-1:0];
                    if (abort && (st_q.pending || st_q.freq) && !flash_ack) begin
                        st_d.discard = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads are captured together with ack
        if (rd_go) begin
            unique case (wb_adr_i)
                xip_stream_pkg::OFS_STATUS: begin
                    st_d.dat = 32'h0000_0000;
                    st_d.dat[xip_stream_pkg::STAT_FULL_BIT] =
                        st_q.level == xip_stream_pkg::BUF_DEPTH;
                    st_d.dat[xip_stream_pkg::STAT_EMPTY_BIT] =
                        st_q.level == 2'h0;
                    st_d.dat[xip_stream_pkg::STAT_FLUSH_DONE_BIT] =
                        !st_q.flush_busy;
                end
                xip_stream_pkg::OFS_HIT_COUNT: st_d.dat = st_q.hit_cnt;
                xip_stream_pkg::OFS_ACCESS_COUNT: st_d.dat = st_q.acc_cnt;
                xip_stream_pkg::OFS_STREAM_ADDR: st_d.dat = {st_q.saddr, 2'h0};
                xip_stream_pkg::OFS_STREAM_COUNT: st_d.dat = {10'h000, st_q.scount};
                xip_stream_pkg::OFS_STREAM_DATA: begin
                    st_d.dat = wb_pop ? rd_word : 32'h0000_0000;
                end
                default: st_d.dat = 32'h0000_0000;
            endcase
        end

        // request follows the buffer's next level
        st_d.dreq = st_d.level != 2'h0;
    end

    // ------------------------------------------------------------------
    // registers; reset also starts a flush
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.slot0 <= xip_stream_pkg::RST_BUF_DATA;
            st_q.slot1 <= xip_stream_pkg::RST_BUF_DATA;
            st_q.level <= 2'h0;
            st_q.hit_cnt <= xip_stream_pkg::RST_COUNTER;
            st_q.acc_cnt <= xip_stream_pkg::RST_COUNTER;
            st_q.saddr <= xip_stream_pkg::RST_STREAM_ADDR;
            st_q.scount <= xip_stream_pkg::RST_STREAM_COUNT;
            st_q.pending <= 1'b0;
            st_q.discard <= 1'b0;
            st_q.freq <= 1'b0;
            st_q.flush_cnt <= 12'h000;
            st_q.flush_busy <= 1'b1;
            st_q.ack <= 1'b0;
            st_q.dat <= 32'h0000_0000;
            st_q.dreq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from state
    // ------------------------------------------------------------------
    assign wb_dat_o = st_q.dat;
    assign wb_ack_o = st_q.ack;
    // the head slot is always visible, so an aux read needs no wait
    assign aux_rdata = st_q.slot0;
    assign stream_dreq = st_q.dreq;
    assign flush_active = st_q.flush_busy;
    assign flash_req = st_q.freq;
    assign flash_addr = {st_q.saddr, 2'h0};

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    buf_level_a: assert property (st_q.level <= 2'h2)
        else $error("buffer level above two");

    full_status_a: assert property (rd_go && wb_adr_i == xip_stream_pkg::OFS_STATUS
        |=> wb_dat_o[2] == ($past(st_q.level) == 2'h2) && wb_dat_o[1] == ($past(st_q.level) == 2'h0))
        else $error("status full or empty bit wrong");

    flush_len_a: assert property ($rose(st_q.flush_busy) && st_q.flush_cnt == 12'h000
        |-> st_q.flush_busy [*8])
        else $error("flush ended too early");

    hit_sat_a: assert property (st_q.hit_cnt == 32'hFFFF_FFFF && !wr_go
        |=> st_q.hit_cnt == 32'hFFFF_FFFF)
        else $error("hit counter wrapped");

    acc_clear_a: assert property (wr_go && wb_adr_i == xip_stream_pkg::OFS_ACCESS_COUNT
        |=> st_q.acc_cnt <= 32'h0000_0001)
        else $error("access counter not cleared");

    free_slot_a: assert property (flash_req |-> st_q.level < 2'h2)
        else $error("read issued into a full buffer");

    addr_step_a: assert property (push |=> flash_addr == $past(flash_addr) + 32'h0000_0004
        || $past(wr_go))
        else $error("stream address did not advance");

    dreq_data_a: assert property (stream_dreq == (st_q.level != 2'h0))
        else $error("dma request disagrees with buffer");

    idle_flash_a: assert property ($rose(st_q.pending) |-> !$past(flash_busy))
        else $error("read issued while flash busy");

    ack_one_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not single cycle");

    // ------------------------------------------------------------------
    // checker-only helper: cycles the current flush has been running
    // ------------------------------------------------------------------
    // a software request restarts the count, so a re-flush mid-way is not
    // taken for an overrun; the datapath never reads this counter
    logic flush_req_seen;
    logic [11:0] flush_seen_q;

    assign flush_req_seen = wr_go && wb_adr_i == xip_stream_pkg::OFS_FLUSH_CTRL
        && wb_sel_i[0] && wb_dat_i[xip_stream_pkg::FLUSH_GO_BIT];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flush_seen_q <= 12'h000;
        end else if (flush_req_seen) begin
            flush_seen_q <= 12'h000;
        end else if (flush_active && flush_seen_q != 12'hFFF) begin
            flush_seen_q <= flush_seen_q + 12'h001;
        end else if (!flush_active) begin
            flush_seen_q <= 12'h000;
        end
    end

    flush_time_a: assert property ($fell(flush_active)
        |-> flush_seen_q == xip_stream_pkg::FLUSH_CYCLES)
        else $error("flush length differs from flush time");

    flush_ready_a: assert property (rd_go && wb_adr_i == xip_stream_pkg::OFS_STATUS
        |=> wb_dat_o[0] == !$past(flush_active))
        else $error("flush-done bit disagrees with flush state");

    hit_step_a: assert property (cache_hit && !wr_go && st_q.hit_cnt != 32'hFFFF_FFFF
        |=> st_q.hit_cnt == $past(st_q.hit_cnt) + 32'h0000_0001)
        else $error("hit counter missed an event");

    acc_step_a: assert property (cache_access && !wr_go && st_q.acc_cnt != 32'hFFFF_FFFF
        |=> st_q.acc_cnt == $past(st_q.acc_cnt) + 32'h0000_0001)
        else $error("access counter missed an event");

    hit_clear_a: assert property (wr_go && wb_adr_i == xip_stream_pkg::OFS_HIT_COUNT
        |=> st_q.hit_cnt <= 32'h0000_0001)
        else $error("hit counter not cleared");

    count_step_a: assert property (push && !wr_go
        |=> st_q.scount == $past(st_q.scount) - 22'h00_0001)
        else $error("stream count did not step down");

    halt_zero_a: assert property (st_q.scount == 22'h00_0000 |=> !flash_req)
        else $error("read issued with a zero count");

    discard_drop_a: assert property (flash_ack && st_q.discard && npop == 2'h0
        |=> st_q.level == $past(st_q.level))
        else $error("cancelled read reached the buffer");

    fill_c: cover property (st_q.level == 2'h2);
    stream_end_c: cover property (push && st_q.scount == 22'h00_0001);
    abort_c: cover property (abort && st_q.pending);
    aux_pop_c: cover property (aux_pop && wb_pop);
    flush_done_c: cover property ($fell(flush_active));

endmodule : xip_stream_status_counters

`default_nettype wire

// >>> verification/flash_model.sv
// flash stand-in for the streaming engine: one read at a time
// assumes requests are one-cycle pulses on the same mclk as the block
`timescale 1ns/1ps
`default_nettype none

module flash_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic flash_req,
    input wire logic [31:0] flash_addr,
    input wire logic [7:0] delay,
    output logic flash_ack,
    output logic [31:0] flash_rdata
);
    logic [31:0] addr_q;
    logic [8:0] cnt_q;

    // answer delay+2 cycles after the request; the data line toggles
    // between answers so a late sample never looks like a good word
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 9'h000;
            flash_ack <= 1'b0;
            flash_rdata <= 32'h0000_0000;
            addr_q <= 32'h0000_0000;
        end else begin
            flash_ack <= 1'b0;
            flash_rdata <= ~flash_rdata;
            if (flash_req) begin
                addr_q <= flash_addr;
                cnt_q <= {1'b0, delay} + 9'h001;
            end else if (cnt_q == 9'h001) begin
                flash_ack <= 1'b1;
                flash_rdata <= addr_q ^ 32'h5A5A_0000;
                cnt_q <= 9'h000;
            end else if (cnt_q != 9'h000) begin
                cnt_q <= cnt_q - 9'h001;
            end
        end
    end
endmodule : flash_model

`default_nettype wire

// >>> verification/xip_stream_status_counters_test.sv
// self-checking bench for the streaming, status and counter block
// assumes the flash model file and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none

module xip_stream_status_counters_test;
    logic mclk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, aux_rd, dreq;
    logic cache_access, cache_hit, flush_active, flash_busy, flash_req, flash_ack;
    logic [7:0] wb_adr, fl_delay;
    logic [31:0] wb_dat, wb_rdat, aux_rdata, flash_addr, flash_rdata, rd;
    int n_mismatch = 0;
    int n_checks = 0;

    xip_stream_status_counters u_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .aux_rd(aux_rd),
        .aux_rdata(aux_rdata), .stream_dreq(dreq), .cache_access(cache_access),
        .cache_hit(cache_hit), .flush_active(flush_active), .flash_busy(flash_busy),
        .flash_req(flash_req), .flash_addr(flash_addr), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata));
    flash_model u_flash (.mclk(mclk), .rst_b(rst_b), .flash_req(flash_req),
        .flash_addr(flash_addr), .delay(fl_delay), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata));

    // -----------------------------------------------------------------
    // shared helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] w(input logic [31:0] a);
        return a ^ 32'h5A5A_0000;
    endfunction : w

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // classic cycle: hold everything until ack, release after it
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
        while (rd[b] !== v && n < 400) begin
            bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
            n++;
        end
        check({31'h0, rd[b]}, {31'h0, v});
    endtask : poll

    // no flash request may appear for c cycles
    task automatic quiet(input int c);
        int hits;
        hits = 0;
        repeat (c) begin
            @(posedge mclk);
            if (flash_req !== 1'b0) hits++;
        end
        check(32'(hits), 32'h0);
    endtask : quiet

    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic flushes();
        bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0000_0002);
        check({31'h0, flush_active}, 32'h1);
        poll(0, 1'b1);
        check({31'h0, flush_active}, 32'h0);
        bus(1'b1, xip_stream_pkg::OFS_FLUSH_CTRL, 32'h0000_0001);
        check({31'h0, flush_active}, 32'h1);
        bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0000_0002);
        poll(0, 1'b1);
    endtask : flushes

    // back-to-back events, then clear each counter with junk data
    task automatic counters();
        for (int i = 0; i < 5; i++) begin
            cache_access <= 1'b1;
            cache_hit <= 1'(i < 3);
            @(posedge mclk);
        end
        cache_access <= 1'b0;
        cache_hit <= 1'b0;
        @(posedge mclk);
        bus(1'b0, xip_stream_pkg::OFS_HIT_COUNT, 32'h0);
        check(rd, 32'h0000_0003);
        bus(1'b0, xip_stream_pkg::OFS_ACCESS_COUNT, 32'h0);
        check(rd, 32'h0000_0005);
        bus(1'b1, xip_stream_pkg::OFS_HIT_COUNT, 32'hDEAD_BEEF);
        bus(1'b0, xip_stream_pkg::OFS_HIT_COUNT, 32'h0);
        check(rd, 32'h0000_0000);
        bus(1'b0, xip_stream_pkg::OFS_ACCESS_COUNT, 32'h0);
        check(rd, 32'h0000_0005);
        bus(1'b1, xip_stream_pkg::OFS_ACCESS_COUNT, 32'h0000_0001);
        bus(1'b0, xip_stream_pkg::OFS_ACCESS_COUNT, 32'h0);
        check(rd, 32'h0000_0000);
    endtask : counters

    task automatic stream();
        flash_busy <= 1'b1;
        bus(1'b1, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0000_0103);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0);
        check(rd, 32'h0000_0100);
        bus(1'b1, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0000_0003);
        quiet(20);
        flash_busy <= 1'b0;
        poll(2, 1'b1);
        check({31'h0, dreq}, 32'h1);
        quiet(20);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0);
        check(rd, 32'h0000_0108);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0);
        check(rd, 32'h0000_0001);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_DATA, 32'h0);
        check(rd, w(32'h0000_0100));
        poll(2, 1'b1);
        aux_rd <= 1'b1;
        @(posedge mclk);
        check(aux_rdata, w(32'h0000_0104));
        @(posedge mclk);
        check(aux_rdata, w(32'h0000_0108));
        aux_rd <= 1'b0;
        bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0000_0003);
        check({31'h0, dreq}, 32'h0);
        // a data read of an empty buffer returns zero and pops nothing
        bus(1'b0, xip_stream_pkg::OFS_STREAM_DATA, 32'h0);
        check(rd, 32'h0000_0000);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0);
        check(rd, 32'h0000_0000);
    endtask : stream

    // abort with a read in flight, then restart once the cancelled read is back
    task automatic abort_restart();
        fl_delay <= 8'd30;
        bus(1'b1, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0000_0200);
        bus(1'b1, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0000_0004);
        repeat (5) @(posedge mclk);
        bus(1'b1, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0);
        quiet(60);
        bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0000_0003);
        fl_delay <= 8'd2;
        bus(1'b1, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0000_0300);
        bus(1'b1, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0000_0001);
        poll(1, 1'b0);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_DATA, 32'h0);
        check(rd, w(32'h0000_0300));
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0000_0000);
    endtask : abort_restart

    // reset in mid-run with words buffered: buffer empties, a flush runs
    task automatic reset_mid();
        bus(1'b1, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0000_0400);
        bus(1'b1, xip_stream_pkg::OFS_STREAM_COUNT, 32'h0000_0002);
        poll(2, 1'b1);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        bus(1'b0, xip_stream_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0000_0002);
        check({31'h0, dreq}, 32'h0);
        bus(1'b0, xip_stream_pkg::OFS_STREAM_ADDR, 32'h0);
        check(rd, 32'h0000_0000);
        poll(0, 1'b1);
    endtask : reset_mid

    // -----------------------------------------------------------------
    // clock, watchdog and main sequence
    // -----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // the whole run needs little over a thousand cycles; this leaves room
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        {wb_cyc, wb_stb, wb_we, aux_rd, cache_access, cache_hit, flash_busy} = 7'h00;
        wb_adr = 8'h00;
        wb_dat = 32'h0000_0000;
        fl_delay = 8'd3;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        flushes();
        counters();
        stream();
        abort_restart();
        reset_mid();
        complete_run();
    end
endmodule : xip_stream_status_counters_test

`default_nettype wire
